// *** verilog/xmd_datapath.sv ***
`timescale 1ns/100ps
module xmd_datapath
	import xmd_pkg::*;
(
	input  wire logic       i_core_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_clk_en,
	input  wire logic       i_op_valid,
	input  wire xmd_op_t    i_op,
	input  wire logic [2:0] i_bit_sel,
	input  wire logic [7:0] i_mem_rdata,
	input  wire logic [5:0] i_flags,
	output logic      [7:0] o_acc,
	output logic      [7:0] o_mem_wdata,
	output logic            o_mem_we,
	output logic      [5:0] o_flags,
	output logic      [5:0] o_flags_we,
	output logic            o_skip,
	output logic            o_busy
);
	// --------------------------------------------------------
	// state
	// --------------------------------------------------------
	typedef enum logic [1:0]
	{
		XMD_S_IDLE,
		XMD_S_DUMMY
	} xmd_fsm_t;

	typedef struct packed
	{
		xmd_fsm_t   fsm;
		logic [1:0] dummy_cnt;
		logic [7:0] acc;
		logic [7:0] mem_wdata;
		logic       mem_we;
		logic [5:0] flags;
		logic [5:0] flags_we;
		logic       skip;
		logic       busy;
	} xmd_state_t;

	xmd_state_t cur;
	xmd_state_t next_cur;

	logic [7:0] sub_diff;
	logic [5:0] sub_flags;

	// subtraction kept apart for its wide flag logic
	xmd_sub_unit u_sub
	(
		.i_acc      (cur.acc),
		.i_mem      (i_mem_rdata),
		.i_carry    (i_flags[XMD_F_C]),
		.i_zero_old (i_flags[XMD_F_CZ]),
		.o_diff     (sub_diff),
		.o_flags    (sub_flags)
	);

	// --------------------------------------------------------
	// per-op result selection
	// --------------------------------------------------------
	logic [7:0] m;
	logic       c_in;
	logic [7:0] res;
	logic       to_acc;
	logic       to_mem;
	logic       skip_now;
	logic [7:0] bit_mask;

	always_comb
	begin
		m        = i_mem_rdata;
		c_in     = i_flags[XMD_F_C];
		next_cur = cur;
		res      = XMD_ZERO;
		to_acc   = 1'b0;
		to_mem   = 1'b0;
		skip_now = 1'b0;
		bit_mask = XMD_ONE << i_bit_sel;
		next_cur.mem_we   = 1'b0;
		next_cur.flags_we = XMD_FLAG_RESET;
		next_cur.flags    = i_flags;
		next_cur.skip     = 1'b0;
		case (cur.fsm)
			XMD_S_IDLE:
			begin
				next_cur.busy = 1'b0;
				if (i_op_valid)
				begin
					case (i_op)
						XMD_MOVE_TO_ACC:
						begin
							res = m;
							to_acc = 1'b1;
						end
						XMD_MOVE_TO_MEM:
						begin
							res = cur.acc;
							to_mem = 1'b1;
						end
						XMD_OR_TO_ACC, XMD_OR_TO_MEM:
						begin
							res = cur.acc | m;
							to_acc = (i_op == XMD_OR_TO_ACC);
							to_mem = (i_op == XMD_OR_TO_MEM);
							next_cur.flags[XMD_F_Z] = (res == XMD_ZERO);
							next_cur.flags_we[XMD_F_Z] = 1'b1;
						end
						XMD_RL, XMD_RL_TO_ACC:
						begin
							res = {m[6:0], m[7]};
							to_acc = (i_op == XMD_RL_TO_ACC);
							to_mem = (i_op == XMD_RL);
						end
						XMD_RR, XMD_RR_TO_ACC:
						begin
							res = {m[0], m[7:1]};
							to_acc = (i_op == XMD_RR_TO_ACC);
							to_mem = (i_op == XMD_RR);
						end
						XMD_RLC, XMD_RLC_TO_ACC:
						begin
							res = {m[6:0], c_in};
							to_acc = (i_op == XMD_RLC_TO_ACC);
							to_mem = (i_op == XMD_RLC);
							next_cur.flags[XMD_F_C] = m[7];
							next_cur.flags_we[XMD_F_C] = 1'b1;
						end
						XMD_RRC, XMD_RRC_TO_ACC:
						begin
							res = {c_in, m[7:1]};
							to_acc = (i_op == XMD_RRC_TO_ACC);
							to_mem = (i_op == XMD_RRC);
							next_cur.flags[XMD_F_C] = m[0];
							next_cur.flags_we[XMD_F_C] = 1'b1;
						end
						XMD_SBC_TO_ACC, XMD_SBC_TO_MEM:
						begin
							res = sub_diff;
							to_acc = (i_op == XMD_SBC_TO_ACC);
							to_mem = (i_op == XMD_SBC_TO_MEM);
							next_cur.flags = sub_flags;
							next_cur.flags_we = {XMD_FLAG_W{1'b1}};
						end
						XMD_DEC_SKIP, XMD_DEC_SKIP_TO_ACC:
						begin
							res = m - XMD_ONE;
							to_acc = (i_op == XMD_DEC_SKIP_TO_ACC);
							to_mem = (i_op == XMD_DEC_SKIP);
							skip_now = (res == XMD_ZERO);
						end
						XMD_INC_SKIP, XMD_INC_SKIP_TO_ACC:
						begin
							res = m + XMD_ONE;
							to_acc = (i_op == XMD_INC_SKIP_TO_ACC);
							to_mem = (i_op == XMD_INC_SKIP);
							skip_now = (res == XMD_ZERO);
						end
						XMD_SET_ONES:
						begin
							res = XMD_ALL_ONES;
							to_mem = 1'b1;
						end
						XMD_SET_BIT:
						begin
							res = m | bit_mask;
							to_mem = 1'b1;
						end
						XMD_BIT_SKIP_NZ:
						begin
							skip_now = |(m & bit_mask);
						end
						default:
						begin
							res = XMD_ZERO;
						end
					endcase
					if (to_acc)
					begin
						next_cur.acc = res;
					end
					next_cur.mem_we    = to_mem;
					next_cur.mem_wdata = to_mem ? res : cur.mem_wdata;
					next_cur.skip      = skip_now;
					// skip holds off the core for the dummy slot
					if (skip_now)
					begin
						next_cur.fsm       = XMD_S_DUMMY;
						next_cur.dummy_cnt = XMD_DUMMY_COUNT;
						next_cur.busy      = 1'b1;
					end
				end
			end
			XMD_S_DUMMY:
			begin
				// op inputs ignored while the dummy cycle runs; flags still load i_flags
				next_cur.dummy_cnt = cur.dummy_cnt - 2'd1;
				if (cur.dummy_cnt == 2'd1)
				begin
					next_cur.fsm  = XMD_S_IDLE;
					next_cur.busy = 1'b0;
				end
			end
			default:
			begin
				next_cur.fsm = XMD_S_IDLE;
			end
		endcase
	end

	// --------------------------------------------------------
	// state register, frozen while clock enable is low
	// --------------------------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			cur <= '{fsm: XMD_S_IDLE, dummy_cnt: 2'd0, acc: XMD_ACC_RESET,
				mem_wdata: XMD_ZERO, mem_we: 1'b0, flags: XMD_FLAG_RESET,
				flags_we: XMD_FLAG_RESET, skip: 1'b0, busy: 1'b0};
		end
		else if (i_clk_en)
		begin
			cur <= next_cur;
		end
	end

	// outputs straight from the state flops
	assign o_acc       = cur.acc;
	assign o_mem_wdata = cur.mem_wdata;
	assign o_mem_we    = cur.mem_we;
	assign o_flags     = cur.flags;
	assign o_flags_we  = cur.flags_we;
	assign o_skip      = cur.skip;
	assign o_busy      = cur.busy;

	// --------------------------------------------------------
	// checks
	// --------------------------------------------------------
	sequence skip_issue_s;
		i_clk_en && i_op_valid && !cur.busy && i_op == XMD_DEC_SKIP && i_mem_rdata == XMD_ONE;
	endsequence

	// busy for exactly the one dummy slot, then free again
	sequence dummy_run_s;
		o_skip && o_busy ##1 !o_busy && !o_skip;
	endsequence

	dec_skip_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		skip_issue_s |=> o_mem_we && o_mem_wdata == XMD_ZERO && o_skip)
		else $error("decrement to zero did not skip");

	skip_cycles_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		skip_issue_s ##1 i_clk_en |-> dummy_run_s)
		else $error("skip did not hold dummy cycle");

	move_acc_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_clk_en && i_op_valid && !o_busy && i_op == XMD_MOVE_TO_ACC
		|=> o_acc == $past(i_mem_rdata) && o_flags_we == XMD_FLAG_RESET && !o_mem_we)
		else $error("move to acc wrong");

	or_zero_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_clk_en && i_op_valid && !o_busy && i_op == XMD_OR_TO_MEM
		|=> o_mem_we && o_flags_we[XMD_F_Z]
			&& o_flags[XMD_F_Z] == (o_mem_wdata == XMD_ZERO))
		else $error("or to mem zero flag wrong");

	rot_left_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_clk_en && i_op_valid && !o_busy && i_op == XMD_RL
		|=> o_mem_wdata == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])})
		else $error("rotate left wrong");

	rlc_carry_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_clk_en && i_op_valid && !o_busy && i_op == XMD_RLC_TO_ACC
		|=> o_flags[XMD_F_C] == $past(i_mem_rdata[7]) && !o_mem_we
			&& o_acc[0] == $past(i_flags[XMD_F_C]))
		else $error("rotate through carry wrong");

	sbc_carry_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_clk_en && i_op_valid && !o_busy && i_op == XMD_SBC_TO_ACC && i_flags[XMD_F_C]
		|=> o_flags[XMD_F_C] == ($past(o_acc) >= $past(i_mem_rdata)))
		else $error("subtract carry wrong");

	set_bit_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_clk_en && i_op_valid && !o_busy && i_op == XMD_SET_BIT
		|=> o_mem_we
			&& o_mem_wdata == ($past(i_mem_rdata) | (XMD_ONE << $past(i_bit_sel))))
		else $error("set bit wrong");

	bit_skip_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_clk_en && i_op_valid && !o_busy && i_op == XMD_BIT_SKIP_NZ
		|=> o_skip == $past(i_mem_rdata[i_bit_sel]) && !o_mem_we)
		else $error("bit skip wrong");
endmodule

// *** verilog/xmd_pkg.sv ***
package xmd_pkg;

	// ------------------------------------------------------------
	// operation codes presented by the decoder
	// ------------------------------------------------------------
	typedef enum logic [4:0]
	{
		XMD_NOP,
		XMD_MOVE_TO_ACC,
		XMD_MOVE_TO_MEM,
		XMD_OR_TO_ACC,
		XMD_OR_TO_MEM,
		XMD_RL,
		XMD_RL_TO_ACC,
		XMD_RLC,
		XMD_RLC_TO_ACC,
		XMD_RR,
		XMD_RR_TO_ACC,
		XMD_RRC,
		XMD_RRC_TO_ACC,
		XMD_SBC_TO_ACC,
		XMD_SBC_TO_MEM,
		XMD_DEC_SKIP,
		XMD_DEC_SKIP_TO_ACC,
		XMD_SET_ONES,
		XMD_SET_BIT,
		XMD_INC_SKIP,
		XMD_INC_SKIP_TO_ACC,
		XMD_BIT_SKIP_NZ
	} xmd_op_t;

	// ------------------------------------------------------------
	// widths, values and timing
	// ------------------------------------------------------------
	localparam int         XMD_DATA_W      = 8;
	localparam int         XMD_BIT_SEL_W   = 3;
	localparam logic [7:0] XMD_ALL_ONES    = 8'h_FF;
	localparam logic [7:0] XMD_ZERO        = 8'h_00;
	localparam logic [7:0] XMD_ONE         = 8'h_01;
	localparam logic [7:0] XMD_ACC_RESET   = 8'h_00;
	localparam int         XMD_SKIP_CYCLES = 3;
	localparam logic [1:0] XMD_DUMMY_COUNT = 2'(XMD_SKIP_CYCLES - 2);

	// flag vector positions
	localparam int XMD_F_C  = 0;
	localparam int XMD_F_AC = 1;
	localparam int XMD_F_Z  = 2;
	localparam int XMD_F_OV = 3;
	localparam int XMD_F_SC = 4;
	localparam int XMD_F_CZ = 5;
	localparam int XMD_FLAG_W = 6;
	localparam logic [5:0] XMD_FLAG_RESET = 6'h_00;

endpackage

// *** verilog/xmd_sub_unit.sv ***
`timescale 1ns/100ps
module xmd_sub_unit
	import xmd_pkg::*;
(
	input  wire logic [7:0] i_acc,
	input  wire logic [7:0] i_mem,
	input  wire logic       i_carry,
	input  wire logic       i_zero_old,
	output logic      [7:0] o_diff,
	output logic      [5:0] o_flags
);
	// --------------------------------------------------------
	// subtract with borrow and flag derivation
	// --------------------------------------------------------
	logic [8:0] full;
	logic [4:0] low;
	logic       ov;
	logic       zero;

	// borrow in is the inverted carry
	always_comb
	begin
		full = {1'b0, i_acc} - {1'b0, i_mem} - {8'h_00, ~i_carry};
		low  = {1'b0, i_acc[3:0]} - {1'b0, i_mem[3:0]} - {4'h_0, ~i_carry};
		o_diff = full[7:0];
		zero = (full[7:0] == XMD_ZERO);
		ov = (i_acc[7] != i_mem[7]) && (full[7] != i_acc[7]);
		o_flags = XMD_FLAG_RESET;
		o_flags[XMD_F_C]  = ~full[8];
		o_flags[XMD_F_AC] = ~low[4];
		o_flags[XMD_F_Z]  = zero;
		o_flags[XMD_F_OV] = ov;
		o_flags[XMD_F_SC] = full[7] ^ ov;
		// cumulative zero: stays zero only if previous result was zero
		o_flags[XMD_F_CZ] = zero & i_zero_old;
	end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/100ps
module tb_top
	import xmd_pkg::*;
;
	logic       i_core_clk;
	logic       i_sys_rst;
	logic       i_clk_en;
	logic       i_op_valid;
	xmd_op_t    i_op;
	logic [2:0] i_bit_sel;
	logic [7:0] i_mem_rdata;
	logic [5:0] i_flags;
	logic [7:0] o_acc;
	logic [7:0] o_mem_wdata;
	logic       o_mem_we;
	logic [5:0] o_flags;
	logic [5:0] o_flags_we;
	logic       o_skip;
	logic       o_busy;
	int         num_errors;
	int         samples_checked;
	logic [7:0] acc;

	xmd_datapath u_xmd_datapath (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_clk_en(i_clk_en), .i_op_valid(i_op_valid), .i_op(i_op), .i_bit_sel(i_bit_sel),
		.i_mem_rdata(i_mem_rdata), .i_flags(i_flags), .o_acc(o_acc),
		.o_mem_wdata(o_mem_wdata), .o_mem_we(o_mem_we), .o_flags(o_flags),
		.o_flags_we(o_flags_we), .o_skip(o_skip), .o_busy(o_busy));

	// ----------------------------------------
	// clock, 40 ns period
	// ----------------------------------------
	initial
	begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end

	// ----------------------------------------
	// checking helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run;
		$display("errors %0d, comparisons %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// one op: present, check registered answer, wait out the dummy cycle
	task automatic run(input xmd_op_t op, input logic [7:0] m, input logic [2:0] b,
		input logic [5:0] f, input logic [7:0] ea, input logic ew, input logic [7:0] ed,
		input logic es, input logic [5:0] efw, input logic [5:0] ef);
		i_op = op;
		i_mem_rdata = m;
		i_bit_sel = b;
		i_flags = f;
		i_op_valid = 1'b1;
		@(negedge i_core_clk);
		i_op_valid = 1'b0;
		chk(o_acc, ea);
		chk({7'h0, o_mem_we}, {7'h0, ew});
		if (ew)
			chk(o_mem_wdata, ed);
		chk({6'h0, o_skip, o_busy}, {6'h0, es, es});
		chk({2'h0, o_flags_we}, {2'h0, efw});
		chk({2'h0, o_flags & efw}, {2'h0, ef & efw});
		acc = ea;
		if (es)
		begin
			@(negedge i_core_clk);
			chk({6'h0, o_skip, o_busy}, 8'h00);
		end
	endtask

	// reference borrow arithmetic: {diff, cz, sc, ov, z, ac, c}
	function automatic logic [13:0] sbc(input logic [7:0] a, m, input logic c, cz);
		logic [8:0] d;
		logic [4:0] l;
		logic       ov;
		logic       z;
		d = {1'b0, a} - {1'b0, m} - {8'h0, ~c};
		l = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
		ov = (a[7] ^ m[7]) & (d[7] ^ a[7]);
		z = (d[7:0] == 8'h00);
		sbc = {d[7:0], z & cz, d[7] ^ ov, ov, z, ~l[4], ~d[8]};
	endfunction

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_move_or;
		run(XMD_MOVE_TO_ACC, 8'h5A, 0, 6'h3F, 8'h5A, 0, 0, 0, 0, 0);
		run(XMD_MOVE_TO_MEM, 8'h00, 0, 0, 8'h5A, 1, 8'h5A, 0, 0, 0);
		run(XMD_OR_TO_ACC, 8'h81, 0, 6'h04, 8'hDB, 0, 0, 0, 6'h04, 6'h00);
		run(XMD_MOVE_TO_ACC, 8'h00, 0, 0, 8'h00, 0, 0, 0, 0, 0);
		run(XMD_OR_TO_MEM, 8'h00, 0, 0, 8'h00, 1, 8'h00, 0, 6'h04, 6'h04);
	endtask

	task automatic t_rotate;
		run(XMD_RL, 8'h96, 0, 0, acc, 1, 8'h2D, 0, 0, 0);
		run(XMD_RL_TO_ACC, 8'h96, 0, 0, 8'h2D, 0, 0, 0, 0, 0);
		run(XMD_RLC, 8'h96, 0, 6'h00, acc, 1, 8'h2C, 0, 6'h01, 6'h01);
		run(XMD_RLC_TO_ACC, 8'h16, 0, 6'h01, 8'h2D, 0, 0, 0, 6'h01, 6'h00);
		run(XMD_RR, 8'h96, 0, 0, acc, 1, 8'h4B, 0, 0, 0);
		run(XMD_RR_TO_ACC, 8'h97, 0, 0, 8'hCB, 0, 0, 0, 0, 0);
		run(XMD_RRC, 8'h96, 0, 6'h01, acc, 1, 8'hCB, 0, 6'h01, 6'h00);
		run(XMD_RRC_TO_ACC, 8'h97, 0, 6'h00, 8'h4B, 0, 0, 0, 6'h01, 6'h01);
	endtask

	task automatic t_sbc(input logic [7:0] a, m, input logic c, cz, tomem);
		logic [13:0] r;
		run(XMD_MOVE_TO_ACC, a, 0, 0, a, 0, 0, 0, 0, 0);
		r = sbc(a, m, c, cz);
		if (tomem)
			run(XMD_SBC_TO_MEM, m, 0, {cz, 4'h0, c}, a, 1, r[13:6], 0, 6'h3F, r[5:0]);
		else
			run(XMD_SBC_TO_ACC, m, 0, {cz, 4'h0, c}, r[13:6], 0, 0, 0, 6'h3F, r[5:0]);
	endtask

	task automatic t_count_skip;
		run(XMD_DEC_SKIP, 8'h01, 0, 0, acc, 1, 8'h00, 1, 0, 0);
		run(XMD_DEC_SKIP, 8'h00, 0, 0, acc, 1, 8'hFF, 0, 0, 0);
		run(XMD_DEC_SKIP_TO_ACC, 8'h01, 0, 0, 8'h00, 0, 0, 1, 0, 0);
		run(XMD_DEC_SKIP_TO_ACC, 8'h05, 0, 0, 8'h04, 0, 0, 0, 0, 0);
		run(XMD_INC_SKIP, 8'hFF, 0, 0, acc, 1, 8'h00, 1, 0, 0);
		run(XMD_INC_SKIP, 8'h7F, 0, 0, acc, 1, 8'h80, 0, 0, 0);
		run(XMD_INC_SKIP_TO_ACC, 8'hFF, 0, 0, 8'h00, 0, 0, 1, 0, 0);
		run(XMD_INC_SKIP_TO_ACC, 8'h00, 0, 0, 8'h01, 0, 0, 0, 0, 0);
	endtask

	task automatic t_bits;
		logic [7:0] v;
		v = 8'hA5;
		run(XMD_SET_ONES, 8'h12, 0, 0, acc, 1, 8'hFF, 0, 0, 0);
		for (int i = 0; i < 8; i++)
		begin
			run(XMD_SET_BIT, 8'h5A, 3'(i), 0, acc, 1, 8'h5A | (8'h01 << i), 0, 0, 0);
			run(XMD_BIT_SKIP_NZ, v, 3'(i), 0, acc, 0, 0, v[i], 0, 0);
		end
	endtask

	// op offered in the dummy cycle and while frozen must be dropped
	task automatic t_refuse;
		run(XMD_MOVE_TO_ACC, 8'h11, 0, 0, 8'h11, 0, 0, 0, 0, 0);
		i_op = XMD_DEC_SKIP;
		i_mem_rdata = 8'h01;
		i_op_valid = 1'b1;
		@(negedge i_core_clk);
		chk({7'h0, o_busy}, 8'h01);
		i_op = XMD_MOVE_TO_ACC;
		i_mem_rdata = 8'h33;
		@(negedge i_core_clk);
		i_op_valid = 1'b0;
		chk(o_acc, 8'h11);
		i_clk_en = 1'b0;
		i_op_valid = 1'b1;
		repeat (2) @(negedge i_core_clk);
		chk(o_acc, 8'h11);
		i_op_valid = 1'b0;
		i_clk_en = 1'b1;
		@(negedge i_core_clk);
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		num_errors = 0;
		samples_checked = 0;
		acc = 8'h00;
		i_sys_rst = 1'b1;
		i_clk_en = 1'b1;
		i_op_valid = 1'b0;
		i_op = XMD_NOP;
		i_bit_sel = 3'h0;
		i_mem_rdata = 8'h00;
		i_flags = 6'h00;
		repeat (20) @(negedge i_core_clk);
		i_sys_rst = 1'b0;
		chk(o_acc, XMD_ACC_RESET);
		chk({5'h0, o_mem_we, o_skip, o_busy}, 8'h00);
		t_move_or();
		t_rotate();
		t_sbc(8'h10, 8'h01, 1'b0, 1'b1, 1'b0);
		t_sbc(8'h22, 8'h22, 1'b1, 1'b1, 1'b1);
		t_sbc(8'h80, 8'h01, 1'b1, 1'b0, 1'b0);
		t_sbc(8'h00, 8'h01, 1'b1, 1'b1, 1'b1);
		t_count_skip();
		t_bits();
		t_refuse();
		complete_run();
	end

	// generous bound: the sequence needs under a hundred cycles
	initial
	begin
		#(40 * 4000);
		num_errors++;
		$display("Error at %0t: run did not finish", $time);
		complete_run();
	end
endmodule
